// ===== hw/sdram_pattern_reg_and_geardown.sv
// Pattern register access and gear-down command logic with Avalon-MM registers
//
// Design decisions made here: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Lane k shows location (n+k) mod 4
// - Back-to-back pattern reads stream without gaps
// - Upper nibble and x16 upper byte mirror lower
// - Mode three bit two redirects reads and writes
// - Burst chop returns beats 0-3, then undriven
// - Bank address bits pick location; others ignored
// - Parity latency adds to read data delay
// - Write stores address bits 7:0 as beats
// - Patterns kept until reinitialisation
// - Write location from bank bits; others ignored
// - Reset starts in half-rate sampling
// - Gear command then sync on even edge
// - Quarter rate begins fixed settle after sync
module sdram_pattern_reg_and_geardown (
    // Clock and reset
    input  wire logic                              clk,
    input  wire logic                              rstn,
    // Avalon-MM slave
    input  wire logic [5:0]                        avs_address,
    input  wire logic                              avs_read,
    input  wire logic                              avs_write,
    input  wire logic [31:0]                       avs_writedata,
    input  wire logic [3:0]                        avs_byteenable,
    output logic      [31:0]                       avs_readdata,
    output logic                                   avs_waitrequest,
    // Decoded command from the controller
    input  wire logic                              cmd_valid,
    input  wire pattern_gear_pkg::cmd_type         cmd_code,
    input  wire logic [1:0]                        bank_addr,
    input  wire logic [1:0]                        bank_group,
    input  wire logic [pattern_gear_pkg::ADDR_W-1:0] addr,
    input  wire logic                              sync_pulse,
    // Data lanes
    output logic      [pattern_gear_pkg::DQ_W-1:0] dq_out,
    output logic                                   dq_oe,
    // Status
    output logic                                   gear_2n
);
    import pattern_gear_pkg::*;

    function automatic logic [LAT_W-1:0] total_latency(input logic [4:0] lat,
                                                       input logic [2:0] pl);
        logic [LAT_W-1:0] sum;
        sum = LAT_W'(lat) + LAT_W'(pl);
        return (sum == '0) ? LAT_W'(1) : sum;
    endfunction

    // Mode state
    logic [1:0]     bl_field_reg;
    logic           pattern_en_reg;
    logic [1:0]     page_reg;
    logic           abort_exit_reg;
    logic [2:0]     parity_lat_reg;
    logic [31:0]    pattern_reg;
    width_mode_type width_reg;
    logic [4:0]     latency_reg;

    // Command decode
    logic           sample_en;
    logic [1:0]     gear_state;
    logic           cmd_take;
    logic [2:0]     mr_sel;
    logic           mrs_take;
    logic           read_take;
    logic           write_take;
    logic           read_chop;
    logic [LAT_W-1:0] read_lat;

    assign cmd_take   = cmd_valid && sample_en;
    assign mr_sel     = {bank_group[0], bank_addr};
    assign mrs_take   = cmd_take && (cmd_code == CMD_MRS);
    assign read_take  = cmd_take && (cmd_code == CMD_READ) && pattern_en_reg;
    assign write_take = cmd_take && (cmd_code == CMD_WRITE) && pattern_en_reg;
    // On the fly: A12 high asks for a full burst
    assign read_chop  = (bl_field_reg == BL_FIELD_BC4) ||
                        ((bl_field_reg == BL_FIELD_OTF) && !addr[OTF_BL8_BIT]);
    assign read_lat   = total_latency(latency_reg, parity_lat_reg);

    gear_down_ctrl u_gear (
        .clk          (clk),
        .rstn         (rstn),
        .gear_on_mrs  (mrs_take && (mr_sel == MR_THREE_SEL) && addr[MR3_GEAR_BIT]),
        .gear_off_mrs (mrs_take && (mr_sel == MR_THREE_SEL) && !addr[MR3_GEAR_BIT]),
        .sync_pulse   (sync_pulse),
        .sr_exit      (cmd_take && (cmd_code == CMD_SELF_REFRESH_EXIT)),
        .gear_2n      (gear_2n),
        .sample_en    (sample_en),
        .gear_state   (gear_state)
    );

    // Mode registers loaded by MRS
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bl_field_reg   <= BL_FIELD_BL8;
            pattern_en_reg <= 1'b0;
            page_reg       <= 2'h0;
            abort_exit_reg <= 1'b0;
            parity_lat_reg <= 3'h0;
        end else if (mrs_take) begin
            if (mr_sel == MR_ZERO_SEL) begin
                bl_field_reg <= addr[MR0_BL_LSB +: 2];
            end else if (mr_sel == MR_THREE_SEL) begin
                pattern_en_reg <= addr[MR3_PATTERN_BIT];
                page_reg       <= addr[MR3_PAGE_LSB +: 2];
            end else if (mr_sel == MR_FOUR_SEL) begin
                abort_exit_reg <= addr[MR4_ABORT_BIT];
            end else if (mr_sel == MR_FIVE_SEL) begin
                parity_lat_reg <= addr[MR5_PL_LSB +: 3];
            end
        end
    end

    // Pattern store survives everything but reset
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pattern_reg <= PATTERN_RESET;
        end else if (write_take) begin
            // Bank bits pick the slot; A10 and bank group ignored
            pattern_reg[{bank_addr, 3'b000} +: PATTERN_W] <= addr[PATTERN_W-1:0];
        end
    end

    // Read launch pipeline: one slot per clock of latency
    logic [PIPE_DEPTH-1:0] rd_vld_reg;
    logic [1:0]            rd_loc_reg  [PIPE_DEPTH];
    logic                  rd_chop_reg [PIPE_DEPTH];

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_vld_reg <= '0;
            for (int i = 0; i < PIPE_DEPTH; i++) begin
                rd_loc_reg[i]  <= 2'h0;
                rd_chop_reg[i] <= 1'b0;
            end
        end else begin
            for (int i = 0; i < PIPE_DEPTH - 1; i++) begin
                rd_vld_reg[i]  <= rd_vld_reg[i+1];
                rd_loc_reg[i]  <= rd_loc_reg[i+1];
                rd_chop_reg[i] <= rd_chop_reg[i+1];
            end
            rd_vld_reg[PIPE_DEPTH-1] <= 1'b0;
            if (read_take) begin
                rd_vld_reg[read_lat - LAT_W'(1)]  <= 1'b1;
                rd_loc_reg[read_lat - LAT_W'(1)]  <= bank_addr;
                rd_chop_reg[read_lat - LAT_W'(1)] <= read_chop;
            end
        end
    end

    // Burst sequencer; a new launch may follow beat 7 directly
    logic       out_active_reg;
    logic [2:0] out_beat_reg;
    logic [1:0] out_loc_reg;
    logic       out_chop_reg;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            out_active_reg <= 1'b0;
            out_beat_reg   <= 3'h0;
            out_loc_reg    <= 2'h0;
            out_chop_reg   <= 1'b0;
        end else if (rd_vld_reg[0]) begin
            out_active_reg <= 1'b1;
            out_beat_reg   <= 3'h0;
            out_loc_reg    <= rd_loc_reg[0];
            out_chop_reg   <= rd_chop_reg[0];
        end else if (out_active_reg) begin
            out_beat_reg <= out_beat_reg + 3'h1;
            if (out_beat_reg == 3'(BURST_LAST)) begin
                out_active_reg <= 1'b0;
            end
        end
    end

    logic [DQ_W-1:0] lane_data;

    pattern_lane_map u_lanes (
        .patterns   (pattern_reg),
        .loc        (out_loc_reg),
        .beat       (out_beat_reg),
        .width_mode (width_reg),
        .dq         (lane_data)
    );

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dq_out <= '0;
            dq_oe  <= 1'b0;
        end else begin
            dq_out <= lane_data;
            // Chopped bursts leave beats 4 to 7 undriven
            dq_oe  <= out_active_reg && !(out_chop_reg && out_beat_reg[2]);
        end
    end

    // Avalon slave: one wait cycle per access
    logic        ack_reg;
    logic [31:0] rdata_next;

    assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;

    always_comb begin
        if (avs_address == REG_CTRL_OFS) begin
            rdata_next = {30'h0, width_reg};
        end else if (avs_address == REG_LATENCY_OFS) begin
            rdata_next = {27'h0, latency_reg};
        end else if (avs_address == REG_STATUS_OFS) begin
            rdata_next = {26'h0, abort_exit_reg, gear_state, gear_2n, out_active_reg,
                          pattern_en_reg};
        end else if (avs_address == REG_PATTERN_OFS) begin
            rdata_next = pattern_reg;
        end else if (avs_address == REG_MODE_OFS) begin
            rdata_next = {25'h0, parity_lat_reg, page_reg, bl_field_reg};
        end else begin
            rdata_next = 32'h0000_0000;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ack_reg      <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            ack_reg <= (avs_read || avs_write) && !ack_reg;
            if (avs_read && !ack_reg) begin
                avs_readdata <= rdata_next;
            end
        end
    end

    // Software steers lane width and base latency
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            width_reg   <= CTRL_WIDTH_RESET;
            latency_reg <= LATENCY_RESET;
        end else if (avs_write && ack_reg && avs_byteenable[0]) begin
            if (avs_address == REG_CTRL_OFS) begin
                // Code 3 is not a width; keep the old one
                if (avs_writedata[1:0] != 2'h3) begin
                    width_reg <= width_mode_type'(avs_writedata[1:0]);
                end
            end else if (avs_address == REG_LATENCY_OFS) begin
                latency_reg <= avs_writedata[4:0];
            end
        end
    end

    // Helper tracking of a lone read for latency checks
    logic             trk_reg;
    logic [LAT_W:0]   trk_cnt_reg;
    logic [LAT_W-1:0] trk_lat_reg;
    logic [1:0]       trk_loc_reg;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            trk_reg     <= 1'b0;
            trk_cnt_reg <= '0;
            trk_lat_reg <= '0;
            trk_loc_reg <= 2'h0;
        end else if (read_take) begin
            trk_reg     <= !trk_reg && !(|rd_vld_reg);
            trk_cnt_reg <= '0;
            trk_lat_reg <= read_lat;
            trk_loc_reg <= bank_addr;
        end else if (rd_vld_reg[0]) begin
            trk_reg <= 1'b0;
        end else if (trk_reg) begin
            trk_cnt_reg <= trk_cnt_reg + (LAT_W+1)'(1);
        end
    end

    property p_read_latency;
        @(posedge clk) disable iff (!rstn)
        trk_reg && rd_vld_reg[0] |->
            (trk_cnt_reg + (LAT_W+1)'(1)) == {1'b0, trk_lat_reg} && rd_loc_reg[0] == trk_loc_reg;
    endproperty
    a_read_latency: assert property (p_read_latency)
        else $error("pattern read launched at wrong latency or location");

    property p_stagger;
        @(posedge clk) disable iff (!rstn)
        out_active_reg |=> dq_out[1] ==
            pattern_reg[{$past(out_loc_reg) + 2'h1, $past(out_beat_reg)}];
    endproperty
    a_stagger: assert property (p_stagger)
        else $error("lane one does not carry the next location");

    property p_mirror;
        @(posedge clk) disable iff (!rstn)
        dq_oe && width_reg != WIDTH_X4 |->
            dq_out[7:4] == dq_out[3:0] && (width_reg != WIDTH_X16 || dq_out[15:8] == dq_out[7:0]);
    endproperty
    a_mirror: assert property (p_mirror)
        else $error("upper lanes do not mirror lower lanes");

    property p_full_burst;
        @(posedge clk) disable iff (!rstn)
        $rose(out_active_reg) |-> out_active_reg [*8];
    endproperty
    a_full_burst: assert property (p_full_burst)
        else $error("burst shorter than eight beats");

    property p_back_to_back;
        @(posedge clk) disable iff (!rstn)
        out_active_reg && out_beat_reg == 3'h7 && rd_vld_reg[0] |=>
            out_active_reg && out_beat_reg == 3'h0;
    endproperty
    a_back_to_back: assert property (p_back_to_back)
        else $error("gap between consecutive pattern bursts");

    property p_chop;
        @(posedge clk) disable iff (!rstn)
        out_active_reg && out_chop_reg && out_beat_reg == 3'h4 |=> !dq_oe [*4];
    endproperty
    a_chop: assert property (p_chop)
        else $error("chopped burst drove beats four to seven");

    property p_write_store;
        @(posedge clk) disable iff (!rstn)
        write_take |=> pattern_reg[{$past(bank_addr), 3'b000} +: 8] == $past(addr[7:0]);
    endproperty
    a_write_store: assert property (p_write_store)
        else $error("pattern write stored wrong byte");

    property p_no_redirect;
        @(posedge clk) disable iff (!rstn)
        !pattern_en_reg && !(mrs_take && mr_sel == MR_THREE_SEL) |=> $stable(pattern_reg);
    endproperty
    a_no_redirect: assert property (p_no_redirect)
        else $error("pattern store changed outside pattern mode");

endmodule // sdram_pattern_reg_and_geardown
`default_nettype wire

// ===== hw/pattern_gear_pkg.sv
// Shared constants and types for the pattern register and gear-down block
package pattern_gear_pkg;

    // Data path shape
    localparam int unsigned DQ_W         = 16;
    localparam int unsigned ADDR_W       = 14;
    localparam int unsigned PATTERN_W    = 8;
    localparam int unsigned PATTERN_ALLW = 32;
    localparam int unsigned BURST_LAST   = 7;
    localparam int unsigned LAT_W        = 6;
    localparam int unsigned PIPE_DEPTH   = 40;

    // Command codes presented by the command decoder
    typedef enum logic [2:0] {
        CMD_DESELECT,
        CMD_NOP,
        CMD_MRS,
        CMD_READ,
        CMD_WRITE,
        CMD_REFRESH,
        CMD_SELF_REFRESH_EXIT
    } cmd_type;

    typedef enum logic [1:0] {
        WIDTH_X4,
        WIDTH_X8,
        WIDTH_X16
    } width_mode_type;

    // Mode register select ({bank_group[0], bank_addr}) and field positions
    localparam logic [2:0] MR_ZERO_SEL        = 3'h0;
    localparam logic [2:0] MR_THREE_SEL       = 3'h3;
    localparam logic [2:0] MR_FOUR_SEL        = 3'h4;
    localparam logic [2:0] MR_FIVE_SEL        = 3'h5;
    localparam int unsigned MR0_BL_LSB        = 0;
    localparam int unsigned MR3_PAGE_LSB      = 0;
    localparam int unsigned MR3_PATTERN_BIT   = 2;
    localparam int unsigned MR3_GEAR_BIT      = 3;
    localparam int unsigned MR4_ABORT_BIT     = 9;
    localparam int unsigned MR5_PL_LSB        = 0;
    localparam int unsigned OTF_BL8_BIT       = 12;
    localparam logic [1:0] BL_FIELD_BL8       = 2'h0;
    localparam logic [1:0] BL_FIELD_OTF       = 2'h1;
    localparam logic [1:0] BL_FIELD_BC4       = 2'h2;

    // Register map, byte addresses
    localparam logic [5:0] REG_CTRL_OFS       = 6'h00;
    localparam logic [5:0] REG_LATENCY_OFS    = 6'h04;
    localparam logic [5:0] REG_STATUS_OFS     = 6'h08;
    localparam logic [5:0] REG_PATTERN_OFS    = 6'h0c;
    localparam logic [5:0] REG_MODE_OFS       = 6'h10;

    // Reset values
    localparam width_mode_type CTRL_WIDTH_RESET = WIDTH_X16;
    localparam logic [4:0]  LATENCY_RESET     = 5'h0b;
    localparam logic [31:0] PATTERN_RESET     = 32'h0000_0000;

    // Gear-down timing, in clocks
    localparam logic [5:0] GEAR_COMMAND_SETTLE_CK = 6'h18;

endpackage : pattern_gear_pkg

// ===== hw/pattern_lane_map.sv
// Staggered lane mapping of the four pattern locations onto the data lanes
`timescale 1ns/1ps
`default_nettype none

module pattern_lane_map (
    // Pattern store and beat position
    input  wire logic [31:0]                     patterns,
    input  wire logic [1:0]                      loc,
    input  wire logic [2:0]                      beat,
    input  wire pattern_gear_pkg::width_mode_type width_mode,
    // Lane data
    output logic      [15:0]                     dq
);
    import pattern_gear_pkg::*;

    // Lane k of a nibble shows location (loc + k) mod 4
    function automatic logic lane_bit(input logic [31:0] p, input logic [1:0] l,
                                      input logic [1:0] k, input logic [2:0] b);
        logic [1:0] src;
        src = l + k;
        return p[{src, b}];
    endfunction

    logic [3:0] nib;

    always_comb begin
        for (int k = 0; k < 4; k++) begin
            nib[k] = lane_bit(patterns, loc, 2'(k), beat);
        end
        case (width_mode)
            WIDTH_X4: dq = {12'h000, nib};
            WIDTH_X8: dq = {8'h00, nib, nib};
            default:  dq = {nib, nib, nib, nib};
        endcase
    end

endmodule // pattern_lane_map
`default_nettype wire

// ===== hw/gear_down_ctrl.sv
// Half-rate to quarter-rate command sampling state machine
`timescale 1ns/1ps
`default_nettype none

module gear_down_ctrl (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Events from the command decoder
    input  wire logic       gear_on_mrs,
    input  wire logic       gear_off_mrs,
    input  wire logic       sync_pulse,
    input  wire logic       sr_exit,
    // Sampling control
    output logic            gear_2n,
    output logic            sample_en,
    output logic [1:0]      gear_state
);
    import pattern_gear_pkg::*;

    typedef enum logic [1:0] {GEAR_1N, GEAR_AWAIT_SYNC, GEAR_SETTLE, GEAR_2N} gear_type;

    gear_type   state_reg;
    logic [5:0] cnt_reg;
    logic       phase_reg;
    logic       sync_take;

    // Sync counts only on an even clock from the gear MRS
    assign sync_take  = (state_reg == GEAR_AWAIT_SYNC) && sync_pulse && !cnt_reg[0];
    assign gear_2n    = (state_reg == GEAR_2N);
    assign sample_en  = !gear_2n || !phase_reg;
    assign gear_state = state_reg;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= GEAR_1N;
            cnt_reg   <= 6'h00;
        end else if (gear_off_mrs) begin
            state_reg <= GEAR_1N;
            cnt_reg   <= 6'h00;
        end else begin
            case (state_reg)
                GEAR_1N: begin
                    cnt_reg <= 6'h01;
                    if (gear_on_mrs) begin
                        state_reg <= GEAR_AWAIT_SYNC;
                    end
                end
                GEAR_AWAIT_SYNC: begin
                    cnt_reg <= cnt_reg + 6'h01;
                    if (sync_take) begin
                        state_reg <= GEAR_SETTLE;
                        cnt_reg   <= 6'h01;
                    end
                end
                GEAR_SETTLE: begin
                    cnt_reg <= cnt_reg + 6'h01;
                    if (cnt_reg == GEAR_COMMAND_SETTLE_CK) begin
                        state_reg <= GEAR_2N;
                    end
                end
                default: begin
                    // Quarter rate must be re-synced after self refresh
                    if (sr_exit) begin
                        state_reg <= GEAR_1N;
                    end
                end
            endcase
        end
    end

    // Command phase restarts on the sync edge
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            phase_reg <= 1'b0;
        end else if (sync_take) begin
            phase_reg <= 1'b0;
        end else begin
            phase_reg <= !phase_reg;
        end
    end

    logic [6:0] since_sync_reg;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            since_sync_reg <= 7'h7f;
        end else if (sync_take) begin
            since_sync_reg <= 7'h00;
        end else if (since_sync_reg != 7'h7f) begin
            since_sync_reg <= since_sync_reg + 7'h01;
        end
    end

    property p_settle_time;
        @(posedge clk) disable iff (!rstn)
        $rose(gear_2n) |-> since_sync_reg == 7'(GEAR_COMMAND_SETTLE_CK);
    endproperty
    a_settle_time: assert property (p_settle_time)
        else $error("quarter rate began at wrong settle count");

    property p_no_sync_no_2n;
        @(posedge clk) disable iff (!rstn)
        (state_reg == GEAR_1N) && sync_pulse && !gear_on_mrs |=> !gear_2n [*2];
    endproperty
    a_no_sync_no_2n: assert property (p_no_sync_no_2n)
        else $error("sync without gear command changed rate");

endmodule // gear_down_ctrl
`default_nettype wire

// ===== testbench/mem_ctrl_model.sv
// Memory controller model issuing decoded commands and the gear sync pulse
`timescale 1ns/1ps
`default_nettype none
module mem_ctrl_model (
    // Clock
    input  wire logic                      clk,
    // Command lines
    output var  logic                      cmd_valid,
    output var  pattern_gear_pkg::cmd_type cmd_code,
    output var  logic [1:0]                bank_addr,
    output var  logic [1:0]                bank_group,
    output var  logic [13:0]               addr,
    output var  logic                      sync_pulse
);
    import pattern_gear_pkg::*;
    initial begin
        cmd_valid = 1'b0;
        cmd_code = CMD_DESELECT;
        bank_addr = 2'h0;
        bank_group = 2'h0;
        addr = 14'h0;
        sync_pulse = 1'b0;
    end
    // Idle gaps cover recovery and update delays
    // Bus inversion and fine refresh never issued
    // Exit sent no sooner than the abort bit allows
    task automatic send(input cmd_type c, input logic [2:0] sel, input logic [13:0] a, input int h);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_code <= c;
        bank_addr <= sel[1:0];
        bank_group <= {1'($urandom), sel[2]};
        addr <= (c == CMD_READ) ? {a[13], 1'b1, a[11:3], 3'h0} : a;
        repeat (h) @(posedge clk);
        cmd_valid <= 1'b0;
        cmd_code <= CMD_DESELECT;
        addr <= ~a;
    endtask
    // Pulse lands two clocks after the gear command edge
    task automatic sync();
        @(posedge clk);
        sync_pulse <= 1'b1;
        @(posedge clk);
        sync_pulse <= 1'b0;
    endtask
endmodule // mem_ctrl_model
`default_nettype wire

// ===== testbench/sdram_pattern_reg_and_geardown_tb.sv
// Self-checking bench for the pattern register and gear-down block
`timescale 1ns/1ps
`default_nettype none
module sdram_pattern_reg_and_geardown_tb;
    import pattern_gear_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [5:0] avs_address = 6'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, q, pat;
    logic avs_waitrequest, cmd_valid, sync_pulse, dq_oe, gear_2n;
    cmd_type cmd_code;
    logic [1:0] bank_addr, bank_group;
    logic [13:0] addr;
    logic [15:0] dq_out;
    int err_count, samples_checked, n;
    always #25 clk = ~clk;
    sdram_pattern_reg_and_geardown dut_u (.clk, .rstn, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .cmd_valid,
        .cmd_code, .bank_addr, .bank_group, .addr, .sync_pulse, .dq_out, .dq_oe, .gear_2n);
    mem_ctrl_model ctl_u (.clk, .cmd_valid, .cmd_code, .bank_addr, .bank_group, .addr,
        .sync_pulse);
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        // Hold until the rising edge that sees waitrequest low
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    function automatic logic [15:0] lanes(logic [31:0] p, int l0, int b);
        for (int l = 0; l < 16; l++) lanes[l] = p[((l0 + l) % 4) * 8 + b];
    endfunction
    // Four reads spaced eight clocks must form one gapless stream
    task automatic burst(input int f, input int w, input int pl);
        logic [15:0] m, e;
        logic [1:0] loc [4];
        // Lanes beyond the selected width must stay low
        m = (w == 2) ? 16'hffff : (w == 1) ? 16'h00ff : 16'h000f;
        bus(1'b1, REG_CTRL_OFS, 32'(w));
        ctl_u.send(CMD_MRS, MR_ZERO_SEL, 14'(f), 1);
        ctl_u.send(CMD_MRS, MR_FIVE_SEL, 14'(pl), 1);
        foreach (loc[i]) loc[i] = 2'($urandom);
        fork
            foreach (loc[i]) begin
                ctl_u.send(CMD_READ, {1'($urandom), loc[i]}, 14'($urandom), 1);
                repeat (6) @(posedge clk);
            end
            begin
                repeat (pl + 6) @(posedge clk);
                for (int j = 0; j < 32; j++) begin
                    @(negedge clk);
                    e = lanes(pat, loc[j / 8], j % 8) & m;
                    check("enable", dq_oe, 32'(f != 2 || j % 8 < 4));
                    if (dq_oe === 1'b1) begin
                        check("lanes", dq_out, e);
                    end
                end
            end
        join
        $display("burst test done");
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        print_verdict();
    end
    initial begin
        static logic [5:0] ofs [6] = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h3c};
        static logic [31:0] rv [6] = '{32'h2, 32'hb, 32'h0, 32'h0, 32'h0, 32'h0};
        void'($urandom(70));
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        bus(1'b1, 6'h3c, 32'hffff_ffff);
        foreach (ofs[i]) begin
            bus(1'b0, ofs[i], 32'h0);
            check("register reset", q, rv[i]);
        end
        ctl_u.send(CMD_READ, 3'h0, 14'h0, 1);
        repeat (20) begin
            @(negedge clk);
            check("idle lanes", dq_oe, 32'h0);
        end
        $display("reset test done");
        ctl_u.send(CMD_MRS, MR_THREE_SEL, 14'h0004, 1);
        for (int i = 0; i < 4; i++) begin
            pat[i * 8 +: 8] = 8'($urandom);
            ctl_u.send(CMD_WRITE, {1'($urandom), 2'(i)}, {6'($urandom), pat[i * 8 +: 8]}, 1);
        end
        bus(1'b0, REG_PATTERN_OFS, 32'h0);
        check("pattern store", q, pat);
        bus(1'b1, REG_LATENCY_OFS, 32'h3);
        for (int i = 0; i < 6; i++) burst(i % 3, (i + 1) % 3, (i / 3) * 2);
        ctl_u.send(CMD_MRS, MR_THREE_SEL, 14'h0, 1);
        ctl_u.send(CMD_WRITE, 3'h1, 14'h00ff, 1);
        bus(1'b0, REG_PATTERN_OFS, 32'h0);
        check("pattern kept", q, pat);
        // Stray sync in half rate must leave the rate alone
        ctl_u.sync();
        ctl_u.send(CMD_MRS, MR_THREE_SEL, 14'h0008, 1);
        ctl_u.sync();
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (gear_2n !== 1'b1 && n < 100);
        // First quarter-rate cycle follows the settle edge
        check("settle", 32'(n), 32'(GEAR_COMMAND_SETTLE_CK) + 32'h1);
        // Held two clocks so one quarter-rate sampling edge takes it
        ctl_u.send(CMD_MRS, MR_FOUR_SEL, 14'h0200, 2);
        bus(1'b0, REG_STATUS_OFS, 32'h0);
        // Abort bit, quarter-rate state and flag
        check("status in 2n", q, 32'h3c);
        ctl_u.send(CMD_SELF_REFRESH_EXIT, 3'h0, 14'h0, 2);
        @(negedge clk);
        check("half rate after exit", gear_2n, 32'h0);
        $display("gear test done");
        print_verdict();
    end
endmodule // sdram_pattern_reg_and_geardown_tb
`default_nettype wire
